// [hw/cdue_defs.svh]
// constants of the chain-port debug control and uart error status block
// assumes inclusion by bare name from the block's modules
//
// Behaviour
// - overrides act only while unlock holds A5
// - daisy override off: manual enables ignored
// - daisy override on: ports follow manual enables
// - manual enables bits 3..0, reset all ones
// - status bits 3..0 show live port states
// - status bit 4: device owns chain ports
// - status bit 5: device owns uart transmitter
// - stacked device keeps uart transmitter off while uart override is off
// - bad first command byte flags, ignores rest
// - ignored frames: no checks, not counted
// - read command with transmitter off flags
// - clear inside command frame flags error
// - later command byte error flags, ignores rest
// - stack/broadcast over uart flags on stacked device unless multidrop
// - command crc failure flags, frame discarded
// - clear while transmitting flags collision
// - response wait cut short flags abort
// - clear inside response frame flags error
// - later response byte error flags, ignores rest
// - response crc failure flags, frame discarded
`ifndef CDUE_DEFS_SVH
`define CDUE_DEFS_SVH

// register offsets
`define CDUE_ADDR_UNLOCK   16'h0700
`define CDUE_ADDR_CTRL1    16'h0701
`define CDUE_ADDR_CTRL2    16'h0702
`define CDUE_ADDR_STAT     16'h0780
`define CDUE_ADDR_CMD_ERR  16'h0781
`define CDUE_ADDR_RESP_ERR 16'h0782

// unlock code and reset values
`define CDUE_UNLOCK_CODE   8'hA5
`define CDUE_UNLOCK_RST    8'h00
`define CDUE_CTRL1_RST     8'h04
`define CDUE_CTRL1_MASK    8'h07
`define CDUE_CTRL2_RST     8'h0F
`define CDUE_CTRL2_MASK    8'h0F
`define CDUE_ERR_RST       8'h00
`define CDUE_PORT_RST      4'h3

// field positions
`define CDUE_CTRL1_DAISY   0
`define CDUE_CTRL1_UART    1
`define CDUE_CTRL1_TXEN    2
`define CDUE_STAT_DAISY    4
`define CDUE_STAT_UART     5

`endif

// [hw/cdue_pkg.sv]
// types shared by the chain-port debug control and uart error status block
// assumes cdue_defs.svh sits on the include path
package cdue_pkg;

	// uart frame events from the deframer, same clock, one-cycle pulses except the two levels
	typedef struct packed {
		logic byte_stb;     // a byte has been received
		logic stop_err;     // that byte had a stop or framing fault
		logic type_bad;     // first byte: bad frame type or reserved bit
		logic is_resp;      // first byte: response frame
		logic is_read;      // first byte: command reads data
		logic is_bcast;     // first byte: stack or broadcast command
		logic last;         // this byte ends the frame
		logic crc_fail;     // with last: crc mismatch
		logic clear_det;    // uart clear condition seen
		logic tx_active;    // level: device transmitting
		logic resp_waiting; // level: waiting for turn to answer
		logic new_cmd;      // a new command starts
	} cdue_uart_ev_t;

	// chain-port transceiver enables, order matches register bits 3..0
	typedef struct packed {
		logic low_port_transmit;
		logic low_port_receive;
		logic high_port_transmit;
		logic high_port_receive;
	} cdue_ports_t;

	typedef enum logic [1:0] {
		CDUE_IDLE,
		CDUE_CMD,
		CDUE_RESP,
		CDUE_IGNORE
	} cdue_frame_st_t;

	// command error flags, bits 5..0
	typedef struct packed {
		logic cmd_init_byte_error;
		logic read_with_tx_off_error;
		logic cmd_early_clear_error;
		logic cmd_byte_error;
		logic unexpected_cmd_error;
		logic cmd_check_error;
	} cdue_cmd_err_t;

	// response and transmit error flags, bits 4..0
	typedef struct packed {
		logic tx_clear_collision;
		logic response_wait_aborted;
		logic resp_early_clear_error;
		logic resp_byte_error;
		logic resp_check_error;
	} cdue_resp_err_t;

endpackage

// [hw/cdue_port_ctl.sv]
// chain-port transceiver enable selection
// assumes manual and automatic enables come from logic on sys_clk
`timescale 1ns/100ps
`include "cdue_defs.svh"

module cdue_port_ctl (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 user_daisy,
	input  wire cdue_pkg::cdue_ports_t manual_en,
	input  wire cdue_pkg::cdue_ports_t auto_en,
	output cdue_pkg::cdue_ports_t      port_en
);

	typedef struct packed {
		logic [3:0] en;
	} cdue_pc_state_t;

	cdue_pc_state_t state_reg;
	cdue_pc_state_t state_next;
	logic [3:0]     sel;

	// per transceiver: manual value under override, device value otherwise
	for (genvar i = 0; i < 4; i++) begin : g_port
		assign sel[i] = user_daisy ? manual_en[i] : auto_en[i];
	end

	// next state
	always_comb begin
		state_next    = state_reg;
		state_next.en = sel;
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg.en <= `CDUE_PORT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign port_en = state_reg.en;

endmodule

// [hw/cdue_top.sv]
// debug register bank: chain-port overrides, ownership status, uart errors
// assumes deframer events and role straps are synchronous to sys_clk
`timescale 1ns/100ps
`include "cdue_defs.svh"

module cdue_top #(
	parameter int ADDR_W = 16
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [ADDR_W-1:0]      reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [7:0]                  reg_rdata,
	input  wire logic                   stacked_role,
	input  wire logic                   multidrop,
	input  wire cdue_pkg::cdue_ports_t  auto_ports,
	input  wire cdue_pkg::cdue_uart_ev_t uart_ev,
	output cdue_pkg::cdue_ports_t       port_en,
	output logic                        uart_tx_enable,
	output logic                        frame_valid,
	output logic                        frame_discard
);

	// offsets need at least eleven address bits
	if (ADDR_W < 11 || ADDR_W > 16) begin : g_bad_addr_w
		$error("cdue_top: ADDR_W must lie between 11 and 16");
	end

	typedef struct packed {
		logic [7:0]               unlock;
		logic [7:0]               ctrl1;
		logic [7:0]               ctrl2;
		cdue_pkg::cdue_frame_st_t st;
		logic                     cur_read;
		cdue_pkg::cdue_cmd_err_t  cmd_err;
		cdue_pkg::cdue_resp_err_t resp_err;
		logic [7:0]               rdata;
		logic                     valid;
		logic                     discard;
		logic                     tx_en;
	} cdue_state_t;

	cdue_state_t              state_reg;
	cdue_state_t              state_next;
	cdue_pkg::cdue_cmd_err_t  cmd_set;
	cdue_pkg::cdue_resp_err_t resp_set;
	cdue_pkg::cdue_cmd_err_t  cmd_clr;
	cdue_pkg::cdue_resp_err_t resp_clr;
	logic [15:0]              addr;
	logic                     unlocked;
	logic                     user_daisy;
	logic                     user_uart;
	logic                     tx_on;
	logic                     valid_set;
	logic                     discard_set;
	logic [7:0]               stat_val;
	cdue_pkg::cdue_frame_st_t st_new;
	logic                     read_new;

	assign addr = 16'(reg_addr);

	// override qualification
	assign unlocked   = (state_reg.unlock == `CDUE_UNLOCK_CODE);
	assign user_daisy = unlocked & state_reg.ctrl1[`CDUE_CTRL1_DAISY];
	assign user_uart  = unlocked & state_reg.ctrl1[`CDUE_CTRL1_UART];

	// uart transmitter: stacked devices hold it off unless software enables it
	assign tx_on = user_uart ? state_reg.ctrl1[`CDUE_CTRL1_TXEN] : ~stacked_role;

	// chain-port enables
	cdue_port_ctl u_port_ctl (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.user_daisy(user_daisy),
		.manual_en (state_reg.ctrl2[3:0]),
		.auto_en   (auto_ports),
		.port_en   (port_en)
	);

	// live status word
	always_comb begin
		stat_val                  = 8'h00;
		stat_val[3:0]             = port_en;
		stat_val[`CDUE_STAT_DAISY] = ~user_daisy;
		stat_val[`CDUE_STAT_UART]  = ~user_uart;
	end

	// frame tracking and error detection
	always_comb begin
		cmd_set     = '0;
		resp_set    = '0;
		valid_set   = 1'b0;
		discard_set = 1'b0;
		st_new      = state_reg.st;
		read_new    = state_reg.cur_read;
		if (uart_ev.clear_det) begin
			// clear ends any frame, including an ignored one
			if (state_reg.st == cdue_pkg::CDUE_CMD) begin
				cmd_set.cmd_early_clear_error = 1'b1;
			end
			if (state_reg.st == cdue_pkg::CDUE_RESP) begin
				resp_set.resp_early_clear_error = 1'b1;
			end
			if (uart_ev.tx_active) begin
				resp_set.tx_clear_collision = 1'b1;
			end
			st_new = cdue_pkg::CDUE_IDLE;
		end else if (uart_ev.byte_stb) begin
			case (state_reg.st)
				cdue_pkg::CDUE_IDLE: begin
					if (uart_ev.is_resp) begin
						// response frames exist on the uart only in multidrop
						st_new = multidrop ? cdue_pkg::CDUE_RESP : cdue_pkg::CDUE_IGNORE;
					end else if (uart_ev.stop_err || uart_ev.type_bad) begin
						cmd_set.cmd_init_byte_error = 1'b1;
						st_new = cdue_pkg::CDUE_IGNORE;
					end else begin
						st_new   = cdue_pkg::CDUE_CMD;
						read_new = uart_ev.is_read;
						if (stacked_role && !multidrop && uart_ev.is_bcast) begin
							cmd_set.unexpected_cmd_error = 1'b1;
						end
					end
				end
				cdue_pkg::CDUE_CMD: begin
					if (uart_ev.stop_err) begin
						cmd_set.cmd_byte_error = 1'b1;
						st_new = cdue_pkg::CDUE_IGNORE;
					end else if (uart_ev.last) begin
						st_new = cdue_pkg::CDUE_IDLE;
						if (uart_ev.crc_fail) begin
							cmd_set.cmd_check_error = 1'b1;
							discard_set = 1'b1;
						end else begin
							valid_set = 1'b1;
							if (state_reg.cur_read && !tx_on) begin
								cmd_set.read_with_tx_off_error = 1'b1;
							end
						end
					end
				end
				cdue_pkg::CDUE_RESP: begin
					if (uart_ev.stop_err) begin
						resp_set.resp_byte_error = 1'b1;
						st_new = cdue_pkg::CDUE_IGNORE;
					end else if (uart_ev.last) begin
						st_new = cdue_pkg::CDUE_IDLE;
						if (uart_ev.crc_fail) begin
							resp_set.resp_check_error = 1'b1;
							discard_set = 1'b1;
						end else begin
							valid_set = 1'b1;
						end
					end
				end
				default: begin
					// ignored frame: no checks and no counting
					st_new = cdue_pkg::CDUE_IGNORE;
				end
			endcase
		end
		// waiting turn for a stack or broadcast read cut short
		if (uart_ev.resp_waiting && (uart_ev.clear_det || uart_ev.new_cmd)) begin
			resp_set.response_wait_aborted = 1'b1;
		end
	end

	// clear-on-read of the error registers
	always_comb begin
		cmd_clr  = '0;
		resp_clr = '0;
		if (reg_rd && addr == `CDUE_ADDR_CMD_ERR) begin
			cmd_clr = '1;
		end else if (reg_rd && addr == `CDUE_ADDR_RESP_ERR) begin
			resp_clr = '1;
		end
	end

	// next state: register writes, read data, flags
	always_comb begin
		state_next          = state_reg;
		state_next.st       = st_new;
		state_next.cur_read = read_new;
		state_next.valid    = valid_set;
		state_next.discard  = discard_set;
		state_next.tx_en    = tx_on;
		// an event in the clearing cycle survives the clear
		state_next.cmd_err  = (state_reg.cmd_err & ~cmd_clr) | cmd_set;
		state_next.resp_err = (state_reg.resp_err & ~resp_clr) | resp_set;
		// writes
		if (reg_wr) begin
			if (addr == `CDUE_ADDR_UNLOCK) begin
				state_next.unlock = reg_wdata;
			end else if (addr == `CDUE_ADDR_CTRL1) begin
				state_next.ctrl1 = reg_wdata & `CDUE_CTRL1_MASK;
			end else if (addr == `CDUE_ADDR_CTRL2) begin
				state_next.ctrl2 = reg_wdata & `CDUE_CTRL2_MASK;
			end
		end
		// reads, data valid the cycle after the strobe only
		state_next.rdata = 8'h00;
		if (reg_rd) begin
			if (addr == `CDUE_ADDR_UNLOCK) begin
				state_next.rdata = state_reg.unlock;
			end else if (addr == `CDUE_ADDR_CTRL1) begin
				state_next.rdata = state_reg.ctrl1;
			end else if (addr == `CDUE_ADDR_CTRL2) begin
				state_next.rdata = state_reg.ctrl2;
			end else if (addr == `CDUE_ADDR_STAT) begin
				state_next.rdata = stat_val;
			end else if (addr == `CDUE_ADDR_CMD_ERR) begin
				state_next.rdata = {2'b00, state_reg.cmd_err};
			end else if (addr == `CDUE_ADDR_RESP_ERR) begin
				state_next.rdata = {3'b000, state_reg.resp_err};
			end else begin
				state_next.rdata = 8'h00;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg.unlock   <= `CDUE_UNLOCK_RST;
			state_reg.ctrl1    <= `CDUE_CTRL1_RST;
			state_reg.ctrl2    <= `CDUE_CTRL2_RST;
			state_reg.st       <= cdue_pkg::CDUE_IDLE;
			state_reg.cur_read <= 1'b0;
			state_reg.cmd_err  <= 6'(`CDUE_ERR_RST);
			state_reg.resp_err <= 5'(`CDUE_ERR_RST);
			state_reg.rdata    <= 8'h00;
			state_reg.valid    <= 1'b0;
			state_reg.discard  <= 1'b0;
			state_reg.tx_en    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata      = state_reg.rdata;
	assign uart_tx_enable = state_reg.tx_en;
	assign frame_valid    = state_reg.valid;
	assign frame_discard  = state_reg.discard;

endmodule

// [tb/cdue_host_model.sv]
// uart host model: issues deframer events toward the bank
// assumes events launch just after a rising edge, one cycle each
`timescale 1ns/100ps

module cdue_host_model (
	input wire logic                sys_clk,
	output cdue_pkg::cdue_uart_ev_t uart_ev
);
	initial uart_ev = '0;

	// one event for one cycle, then quiet
	task automatic put(input logic [11:0] v);
		@(posedge sys_clk);
		uart_ev <= v;
		@(posedge sys_clk);
		uart_ev <= '0;
	endtask
endmodule

// [tb/cdue_top_assertions.sv]
// checker for the debug register bank, bound into cdue_top
// assumes one clock domain and the plain register port
`timescale 1ns/100ps
`include "cdue_defs.svh"

module cdue_chk #(
	parameter int ADDR_W = 16
) (
	input wire logic                    sys_clk,
	input wire logic                    rst,
	input wire logic [ADDR_W-1:0]       reg_addr,
	input wire logic [7:0]              reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_rdata,
	input wire logic                    stacked_role,
	input wire logic                    multidrop,
	input wire cdue_pkg::cdue_ports_t   auto_ports,
	input wire cdue_pkg::cdue_uart_ev_t uart_ev,
	input wire cdue_pkg::cdue_ports_t   port_en,
	input wire logic                    uart_tx_enable,
	input wire logic                    frame_valid,
	input wire logic                    frame_discard
);
	localparam logic [ADDR_W-1:0] A_CTRL2 = ADDR_W'(`CDUE_ADDR_CTRL2);
	localparam logic [ADDR_W-1:0] A_STAT  = ADDR_W'(`CDUE_ADDR_STAT);
	logic [7:0] unl_reg;
	logic [2:0] c1_reg;
	logic [3:0] c2_reg;
	logic       own_daisy;
	logic       own_uart;
	logic       ev_end;
	logic       ev_crc;
	logic       mapped;

	// mirror of the override registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unl_reg <= `CDUE_UNLOCK_RST;
			c1_reg <= 3'h4;
			c2_reg <= 4'hF;
		end else if (reg_wr) begin
			case (reg_addr)
			ADDR_W'(`CDUE_ADDR_UNLOCK): unl_reg <= reg_wdata;
			ADDR_W'(`CDUE_ADDR_CTRL1): c1_reg <= reg_wdata[2:0];
			A_CTRL2: c2_reg <= reg_wdata[3:0];
			default: ;
			endcase
		end
	end

	// owners and frame-end causes
	assign own_daisy = !(unl_reg == `CDUE_UNLOCK_CODE && c1_reg[0]);
	assign own_uart = !(unl_reg == `CDUE_UNLOCK_CODE && c1_reg[1]);
	assign ev_end = uart_ev.byte_stb && uart_ev.last && !uart_ev.clear_det;
	assign ev_crc = ev_end && uart_ev.crc_fail;
	assign mapped = (reg_addr >> 8) == ADDR_W'(16'h0007) && reg_addr[6:0] < 7'h03;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence

	chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_ctrl2_rsvd: assert property (s_rd(A_CTRL2) |=> reg_rdata[7:4] == 4'h0)
		else $error("reserved enable bits set");
	chk_stat_ports: assert property (s_rd(A_STAT) |=> reg_rdata[3:0] == $past(port_en))
		else $error("status ports mismatch");
	chk_stat_owner: assert property (s_rd(A_STAT) |=>
		reg_rdata[7:4] == {2'b00, $past(own_uart), $past(own_daisy)})
		else $error("status owner bits wrong");
	chk_auto_ports: assert property (!rst && own_daisy |=> port_en == $past(auto_ports))
		else $error("ports not under device control");
	chk_manual_ports: assert property (!own_daisy |=> port_en == $past(c2_reg))
		else $error("ports not following manual enables");
	chk_uart_auto: assert property (!rst && own_uart |=> uart_tx_enable == !$past(stacked_role))
		else $error("uart transmitter default wrong");
	chk_uart_manual: assert property (!own_uart |=> uart_tx_enable == $past(c1_reg[2]))
		else $error("uart transmitter override wrong");
	chk_discard_crc: assert property (frame_discard |-> $past(ev_crc) && !frame_valid)
		else $error("discard without crc failure");
	chk_valid_end: assert property (frame_valid |-> $past(ev_end))
		else $error("valid pulse without frame end");
endmodule

bind cdue_top cdue_chk #(.ADDR_W(ADDR_W)) chk_u (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.stacked_role(stacked_role), .multidrop(multidrop), .auto_ports(auto_ports),
	.uart_ev(uart_ev), .port_en(port_en), .uart_tx_enable(uart_tx_enable),
	.frame_valid(frame_valid), .frame_discard(frame_discard)
);

// [tb/cdue_top_tb_top.sv]
// self-checking bench for the debug register bank
// assumes the design, host model and checker are compiled first
`timescale 1ns/100ps

module cdue_top_tb_top;
	logic                    sys_clk;
	logic                    rst;
	logic [15:0]             reg_addr;
	logic [7:0]              reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [7:0]              reg_rdata;
	logic                    stacked_role;
	logic                    multidrop;
	cdue_pkg::cdue_ports_t   auto_ports;
	cdue_pkg::cdue_uart_ev_t uart_ev;
	cdue_pkg::cdue_ports_t   port_en;
	logic                    uart_tx_enable;
	logic                    frame_valid;
	logic                    frame_discard;
	int                      bad_count;
	int                      checked;

	cdue_top dut_u (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.stacked_role(stacked_role), .multidrop(multidrop), .auto_ports(auto_ports),
		.uart_ev(uart_ev), .port_en(port_en), .uart_tx_enable(uart_tx_enable),
		.frame_valid(frame_valid), .frame_discard(frame_discard)
	);
	cdue_host_model host_u (.sys_clk(sys_clk), .uart_ev(uart_ev));

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	task automatic cmp(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
		checked++;
		if ((got & m) !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read strobe, data checked in the following cycle
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, e, m);
	endtask

	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask

	// event frame, valid/discard pulse, flag read, then both flag registers read back clean
	task automatic run(input logic md, input logic sr, input logic [11:0] e1,
		input logic [11:0] e2, input logic [11:0] e3, input logic [15:0] a,
		input logic [7:0] x, input logic [1:0] fv);
		@(posedge sys_clk);
		multidrop <= md;
		stacked_role <= sr;
		host_u.put(e1);
		host_u.put(e2);
		if (e3 !== 12'h000) begin
			host_u.put(e3);
		end
		#1;
		cmp({6'h00, frame_valid, frame_discard}, {6'h00, fv}, 8'h03);
		rd(a, x);
		host_u.put(12'h008);
		rd(16'h0781, 8'h00);
		rd(16'h0782, 8'h00);
	endtask

	task automatic conclude;
		$display("bad_count %0d checked %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		#50000;
		bad_count++;
		conclude;
	end

	// main sequence
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		stacked_role = 1'b0;
		multidrop = 1'b0;
		auto_ports = 4'hA;
		bad_count = 0;
		checked = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(16'h0702, 8'h0F);
		rd(16'h0780, 8'h3A);
		rd(16'h07FF, 8'h00);
		wr(16'h0702, 8'hF5);
		rd(16'h0702, 8'h05);
		wr(16'h0701, 8'h01);
		rd(16'h0780, 8'h3A);
		wr(16'h0700, 8'hA5);
		rd(16'h0780, 8'h25);
		@(posedge sys_clk);
		auto_ports <= 4'h5;
		wr(16'h0700, 8'h00);
		rd(16'h0780, 8'h35);
		@(posedge sys_clk);
		stacked_role <= 1'b1;
		tick;
		cmp({7'h00, uart_tx_enable}, 8'h00, 8'h01);
		wr(16'h0700, 8'hA5);
		wr(16'h0701, 8'h06);
		tick;
		cmp({7'h00, uart_tx_enable}, 8'h01, 8'h01);
		rd(16'h0780, 8'h10, 8'hF0);
		wr(16'h0700, 8'h00);
		run(1'h0, 1'h0, 12'h800, 12'h830, 12'h000, 16'h0781, 8'h01, 2'h1);
		run(1'h0, 1'h0, 12'hA00, 12'h830, 12'h000, 16'h0781, 8'h20, 2'h0);
		run(1'h0, 1'h1, 12'h880, 12'h820, 12'h000, 16'h0781, 8'h10, 2'h2);
		run(1'h0, 1'h0, 12'h800, 12'h008, 12'h000, 16'h0781, 8'h08, 2'h0);
		run(1'h0, 1'h0, 12'h800, 12'hC00, 12'h830, 16'h0781, 8'h04, 2'h0);
		run(1'h0, 1'h1, 12'h840, 12'h820, 12'h000, 16'h0781, 8'h02, 2'h2);
		run(1'h1, 1'h1, 12'h840, 12'h820, 12'h000, 16'h0781, 8'h00, 2'h2);
		run(1'h0, 1'h0, 12'h00C, 12'h000, 12'h000, 16'h0782, 8'h10, 2'h0);
		run(1'h0, 1'h0, 12'h00A, 12'h000, 12'h000, 16'h0782, 8'h08, 2'h0);
		run(1'h0, 1'h0, 12'h003, 12'h000, 12'h000, 16'h0782, 8'h08, 2'h0);
		run(1'h1, 1'h0, 12'h900, 12'h008, 12'h000, 16'h0782, 8'h04, 2'h0);
		run(1'h1, 1'h0, 12'h900, 12'hC00, 12'h830, 16'h0782, 8'h02, 2'h0);
		run(1'h1, 1'h0, 12'h900, 12'h830, 12'h000, 16'h0782, 8'h01, 2'h1);
		run(1'h0, 1'h0, 12'h900, 12'h830, 12'h000, 16'h0782, 8'h00, 2'h0);
		conclude;
	end
endmodule
